// ==== rtl/upcount_time_base_unit.sv ====
// Upcount time-base unit: 16-bit upcounter, buffered prescaler, reload preload and repetition counter.
// Assumes a one-cycle read/write strobe port on clk_i; read data appear one cycle after the read strobe.
`timescale 1ns/1ps
module upcount_time_base_unit #(
    parameter int CNT_W = 16,
    parameter int REP_W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [time_base_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [time_base_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [time_base_pkg::DATA_W-1:0] reg_rdata_o,
    // Slave mode controller update request
    input wire logic slave_update_i,
    // Status
    output logic update_event_o,
    output logic update_flag_o,
    output logic overflow_o
);
    import time_base_pkg::*;

    control_t ctrl_r;
    logic update_flag_r;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] prescale_value_r;
    logic [CNT_W-1:0] prescale_active_r;
    logic [CNT_W-1:0] divider_r;
    logic [CNT_W-1:0] reload_pre_r;
    logic [CNT_W-1:0] reload_shadow_r;
    logic [REP_W-1:0] repeat_count_r;
    logic [REP_W-1:0] repeat_left_r;
    logic [DATA_W-1:0] rdata_r;
    logic update_event_r;
    logic overflow_r;

    // Address decode.
    wire sel_ctrl = (reg_addr_i == OFS_CONTROL);
    wire sel_stat = (reg_addr_i == OFS_STATUS);
    wire sel_evt = (reg_addr_i == OFS_EVENT);
    wire sel_cnt = (reg_addr_i == OFS_COUNT);
    wire sel_psc = (reg_addr_i == OFS_PRESCALE);
    wire sel_arr = (reg_addr_i == OFS_RELOAD);
    wire sel_rep = (reg_addr_i == OFS_REPEAT);

    wire wr_ctrl = reg_wr_i && sel_ctrl;
    wire wr_stat = reg_wr_i && sel_stat;
    wire wr_cnt = reg_wr_i && sel_cnt;
    wire wr_psc = reg_wr_i && sel_psc;
    wire wr_arr = reg_wr_i && sel_arr;
    wire wr_rep = reg_wr_i && sel_rep;

    // The generate bit is a pulse decoded from the write itself, so it never holds and reads as zero.
    wire sw_generate = reg_wr_i && sel_evt && reg_wdata_i[BIT_UG];
    wire forced = sw_generate || slave_update_i;

    // Prescaler tick: counter_enable is registered, so counting begins the cycle after the write.
    wire divider_end = (divider_r == prescale_active_r);
    wire counter_tick = ctrl_r.counter_enable && divider_end;
    wire at_top = (count_r == reload_shadow_r);
    // A null reload blocks the counter, so no overflow is seen.
    wire overflow = counter_tick && at_top && (reload_shadow_r != '0);
    wire rep_zero = (repeat_left_r == '0);
    wire ovf_update = overflow && rep_zero && !ctrl_r.update_disable;
    wire forced_update = forced && !ctrl_r.update_disable;
    wire update_event = ovf_update || forced_update;
    wire set_flag = ovf_update || (forced_update && !ctrl_r.update_request_source);

    wire [CNT_W-1:0] reload_shadow_nxt = update_event ? reload_pre_r : reload_shadow_r;

    // Control register.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_r <= RST_CONTROL;
        end else if (wr_ctrl) begin
            ctrl_r.counter_enable <= reg_wdata_i[BIT_CEN];
            ctrl_r.update_disable <= reg_wdata_i[BIT_UPDATE_DISABLE];
            ctrl_r.update_request_source <= reg_wdata_i[BIT_URS];
            ctrl_r.reload_preload_enable <= reg_wdata_i[BIT_RELOAD_PRELOAD_ENABLE];
        end
    end

    // Update flag: a set in the same cycle as a software clear wins.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            update_flag_r <= 1'b0;
        end else if (set_flag) begin
            update_flag_r <= 1'b1;
        end else if (wr_stat && !reg_wdata_i[BIT_UIF]) begin
            update_flag_r <= 1'b0;
        end
    end

    // Prescaler divider and its buffered ratio.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            divider_r <= '0;
            prescale_active_r <= RST_PRESCALE;
        end else begin
            if (forced || divider_end) begin
                divider_r <= '0;
            end else if (ctrl_r.counter_enable) begin
                divider_r <= divider_r + 1'b1;
            end
            if (update_event) begin
                prescale_active_r <= prescale_value_r;
            end
        end
    end

    // Counter.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            count_r <= RST_COUNT;
        end else if (forced) begin
            count_r <= '0;
        end else if (wr_cnt) begin
            count_r <= reg_wdata_i[CNT_W-1:0];
        end else if (overflow) begin
            count_r <= '0;
        end else if (counter_tick && (reload_shadow_r != '0)) begin
            count_r <= count_r + 1'b1;
        end
    end

    // Preload registers and the reload shadow.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            prescale_value_r <= RST_PRESCALE;
            reload_pre_r <= RST_RELOAD;
            reload_shadow_r <= RST_RELOAD;
            repeat_count_r <= RST_REPEAT;
        end else begin
            if (wr_psc) begin
                prescale_value_r <= reg_wdata_i[CNT_W-1:0];
            end
            if (wr_arr) begin
                reload_pre_r <= reg_wdata_i[CNT_W-1:0];
            end
            if (wr_rep) begin
                repeat_count_r <= reg_wdata_i[REP_W-1:0];
            end
            if (!ctrl_r.reload_preload_enable) begin
                reload_shadow_r <= reload_pre_r;
            end else begin
                reload_shadow_r <= reload_shadow_nxt;
            end
        end
    end

    // Repetition counter.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            repeat_left_r <= RST_REPEAT;
        end else if (update_event || (forced && ctrl_r.update_disable)) begin
            repeat_left_r <= repeat_count_r;
        end else if (overflow) begin
            repeat_left_r <= rep_zero ? repeat_count_r : repeat_left_r - 1'b1;
        end
    end

    // Event outputs, registered for clean timing.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            update_event_r <= 1'b0;
            overflow_r <= 1'b0;
        end else begin
            update_event_r <= update_event;
            overflow_r <= overflow;
        end
    end

    // Read mux; unmapped addresses and the event word read as zero.
    wire [DATA_W-1:0] ctrl_word = {{(DATA_W-8){1'b0}}, ctrl_r.reload_preload_enable, 4'h0,
        ctrl_r.update_request_source, ctrl_r.update_disable, ctrl_r.counter_enable};
    wire [DATA_W-1:0] rd_mux =
        sel_ctrl ? ctrl_word :
        sel_stat ? {{(DATA_W-1){1'b0}}, update_flag_r} :
        sel_cnt ? {{(DATA_W-CNT_W){1'b0}}, count_r} :
        sel_psc ? {{(DATA_W-CNT_W){1'b0}}, prescale_value_r} :
        sel_arr ? {{(DATA_W-CNT_W){1'b0}}, reload_pre_r} :
        sel_rep ? {{(DATA_W-REP_W){1'b0}}, repeat_count_r} :
        '0;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_r <= '0;
        end else if (reg_rd_i) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= '0;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign update_event_o = update_event_r;
    assign update_flag_o = update_flag_r;
    assign overflow_o = overflow_r;
endmodule // upcount_time_base_unit

// ==== rtl/time_base_pkg.sv ====
// Package of the upcount time-base unit: register offsets, field positions and reset values.
// Assumes a plain address/strobe register port and a single 125 MHz clock.
package time_base_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int REP_W = 8;

    // Register offsets (bytes).
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_EVENT = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_PRESCALE = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_RELOAD = 8'h2c;
    localparam logic [ADDR_W-1:0] OFS_REPEAT = 8'h30;

    // Field positions in control_word_one.
    localparam int BIT_CEN = 0;
    localparam int BIT_UPDATE_DISABLE = 1;
    localparam int BIT_URS = 2;
    localparam int BIT_RELOAD_PRELOAD_ENABLE = 7;
    // Field positions in status_word and event_generation_word.
    localparam int BIT_UIF = 0;
    localparam int BIT_UG = 0;

    // Reset values.
    localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
    localparam logic [CNT_W-1:0] RST_PRESCALE = 16'h0000;
    localparam logic [CNT_W-1:0] RST_RELOAD = 16'hffff;
    localparam logic [REP_W-1:0] RST_REPEAT = 8'h00;

    // Software-visible control bits travel together.
    typedef struct packed {
        logic reload_preload_enable;
        logic update_request_source;
        logic update_disable;
        logic counter_enable;
    } control_t;

    localparam control_t RST_CONTROL = '0;
endpackage

// ==== verif/time_base_assertions.sv ====
// Port-level checks for the upcount time-base unit.
// Bound to every instance; tracks the control bits it needs from register writes.
`timescale 1ns/1ps
module time_base_checker
    import time_base_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int REP_W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [time_base_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [time_base_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [time_base_pkg::DATA_W-1:0] reg_rdata_o,
    // Requests and status
    input wire logic slave_update_i,
    input wire logic update_event_o,
    input wire logic update_flag_o,
    input wire logic overflow_o
);
    import time_base_pkg::*;
    logic update_disable_r;
    logic cen_r;
    wire force_w = slave_update_i || (reg_wr_i && reg_addr_i == OFS_EVENT && reg_wdata_i[BIT_UG]);
    wire clr_w = reg_wr_i && reg_addr_i == OFS_STATUS && !reg_wdata_i[BIT_UIF];
    // A mirror of the counter_enable and update_disable control bits, updated at the same edge as the unit's own copy.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            update_disable_r <= 1'b0;
            cen_r <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == OFS_CONTROL) begin
            update_disable_r <= reg_wdata_i[BIT_UPDATE_DISABLE];
            cen_r <= reg_wdata_i[BIT_CEN];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_RD_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
        else $error("read data outside read slot");
    AST_RD_UPPER: assert property ($past(reg_rd_i) |-> reg_rdata_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    AST_EVENT_READ: assert property ($past(reg_rd_i && reg_addr_i == OFS_EVENT) |-> reg_rdata_o == '0)
        else $error("event word read back nonzero");
    AST_OVF_PULSE: assert property (overflow_o |=> !overflow_o)
        else $error("overflow closer than two cycles");
    AST_FORCED: assert property (force_w && !update_disable_r |-> ##[1:2] update_event_o)
        else $error("forced update gave no event");
    AST_DISABLED: assert property (update_disable_r && $past(update_disable_r) |-> !update_event_o)
        else $error("update event while disabled");
    AST_STOPPED: assert property (!cen_r && $past(!cen_r) |-> !overflow_o)
        else $error("overflow while counter stopped");
    AST_FLAG_ROSE: assert property ($rose(update_flag_o) |-> update_event_o || $past(update_event_o))
        else $error("flag set without update event");
    AST_FLAG_FELL: assert property ($fell(update_flag_o) |-> $past(clr_w))
        else $error("flag cleared without write");
endmodule // time_base_checker
bind upcount_time_base_unit time_base_checker #(.CNT_W(CNT_W), .REP_W(REP_W)) u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .slave_update_i(slave_update_i),
    .update_event_o(update_event_o), .update_flag_o(update_flag_o), .overflow_o(overflow_o));

// ==== verif/testbench.sv ====
// Self-checking bench for the upcount time-base unit.
// Drives the register port and slave request directly; no partner model.
`timescale 1ns/1ps
module testbench;
    import time_base_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic slave_up = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic upd_evt;
    logic flag;
    logic ovf;
    int failures = 0;
    int check_count = 0;
    always #4 clk_i = ~clk_i;
    upcount_time_base_unit DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .slave_update_i(slave_up),
        .update_event_o(upd_evt), .update_flag_o(flag), .overflow_o(ovf));
    task automatic summarize();
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    // Skips to the next overflow, then counts cycles up to the one after it.
    task automatic period(output int n);
        for (n = 0; ovf !== 1'b1 && n < 300; n++) @(posedge clk_i) #1;
        n = 0;
        do @(posedge clk_i) #1 n++; while (ovf !== 1'b1 && n < 300);
    endtask
    task automatic test_reset();
        rd_check(OFS_RELOAD, 32'h0000ffff);
        rd_check(OFS_COUNT, 32'h0);
        rd_check(8'h04, 32'h0);
    endtask
    task automatic test_run();
        int n;
        wr_reg(OFS_RELOAD, 32'h3);
        wr_reg(OFS_CONTROL, 32'h01);
        period(n);
        check(n, 32'd4);
        rd_check(OFS_STATUS, 32'h1);
    endtask
    task automatic test_disabled();
        int n;
        wr_reg(OFS_CONTROL, 32'h83);
        wr_reg(OFS_STATUS, 32'h0);
        wr_reg(OFS_RELOAD, 32'h5);
        wr_reg(OFS_PRESCALE, 32'h1);
        period(n);
        check(n, 32'd4);
        wr_reg(OFS_CONTROL, 32'h82);
        wr_reg(OFS_COUNT, 32'h3);
        rd_check(OFS_COUNT, 32'h3);
        @(posedge clk_i);
        slave_up <= 1'b1;
        @(posedge clk_i);
        slave_up <= 1'b0;
        #1 check(upd_evt, 32'h0);
        rd_check(OFS_COUNT, 32'h0);
        rd_check(OFS_STATUS, 32'h0);
        rd_check(OFS_RELOAD, 32'h5);
    endtask
    task automatic test_preload();
        int n;
        wr_reg(OFS_CONTROL, 32'h81);
        period(n);
        check(n, 32'd12);
    endtask
    task automatic test_repeat();
        int n;
        wr_reg(OFS_REPEAT, 32'h2);
        wr_reg(OFS_CONTROL, 32'h85);
        period(n);
        wr_reg(OFS_STATUS, 32'h0);
        wr_reg(OFS_EVENT, 32'h1);
        #1 check(upd_evt, 32'h1);
        rd_check(OFS_STATUS, 32'h0);
        n = 0;
        for (int i = 0; i < 100 && upd_evt !== 1'b1; i++) begin
            @(posedge clk_i);
            #1 n += (ovf === 1'b1);
        end
        check(n, 32'd3);
        check(flag, 32'h1);
        rd_check(OFS_STATUS, 32'h1);
        rd_check(OFS_EVENT, 32'h0);
    endtask
    initial begin
        #40000;
        failures++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        test_reset();
        test_run();
        test_disabled();
        test_preload();
        test_repeat();
        summarize();
    end
endmodule // testbench
